/* hdl/mspin_top.sv */
// Modem status inputs, multifunction pin and AXI4-Lite registers
`default_nettype none

module mspin_top (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        master_reset_in,
  // AXI4-Lite write address
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Modem status pins, active low
  input  wire logic        carrier_detect_in_n,
  input  wire logic        ring_indicator_in_n,
  // Receive FIFO DMA request, active low
  input  wire logic        receive_dma_request_n,
  // Pins and receiver clocking
  output logic             multifunc_out,
  output logic             baud_clock_out,
  output logic             rx_sample_tick,
  // Interrupt
  output logic             irq
);

  // Reset used by everything the master reset clears
  logic rst_mr;
  assign rst_mr = sys_rst | master_reset_in;

  // Bus state
  logic        awready_reg;
  logic        awready_next;
  logic        wready_reg;
  logic        wready_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        aw_got_reg;
  logic        aw_got_next;
  logic        w_got_reg;
  logic        w_got_next;
  logic [3:0]  aw_idx_reg;
  logic [3:0]  aw_idx_next;
  logic [7:0]  wbyte_reg;
  logic [7:0]  wbyte_next;
  logic        wlane_reg;
  logic        wlane_next;
  logic        arready_reg;
  logic        arready_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;

  // Register state
  logic [7:0]  ier_reg;
  logic [7:0]  ier_next;
  logic [7:0]  lcr_reg;
  logic [7:0]  lcr_next;
  logic [7:0]  mcr_reg;
  logic [7:0]  mcr_next;
  logic [1:0]  afr_sel_reg;
  logic [1:0]  afr_sel_next;
  logic [7:0]  div_lo_reg;
  logic [7:0]  div_lo_next;
  logic [7:0]  div_hi_reg;
  logic [7:0]  div_hi_next;
  logic        carrier_chg_reg;
  logic        carrier_chg_next;
  logic        ring_trail_reg;
  logic        ring_trail_next;
  logic [1:0]  evt_stat_reg;
  logic [1:0]  evt_stat_next;
  logic [1:0]  evt_mask_reg;
  logic [1:0]  evt_mask_next;
  logic        irq_reg;
  logic        irq_next;
  logic        mf_reg;
  logic        mf_next;
  logic        baud_out_reg;
  logic        rx_tick_reg;

  // Decode and helper signals
  logic        wr_fire;
  logic        wr_ok;
  logic        rd_fire;
  logic        rd_ok;
  logic [3:0]  rd_idx;
  logic [7:0]  rd_byte;
  logic        dlab;
  logic        msr_rd;
  logic        wr_en;
  logic [1:0]  evt_set;
  logic [1:0]  evt_w1c;
  logic        general_output_two_pin;
  mspin_pkg::mspin_msr_s msr_view;

  // Modem inputs and baud generator
  logic carrier_lvl;
  logic carrier_chg;
  logic ring_lvl;
  logic ring_trail;
  logic baud_tick;
  logic baud_level;

  mspin_edge u_carrier (
    .clk      (clk),
    .rst      (rst_mr),
    .pin_n    (carrier_detect_in_n),
    .level    (carrier_lvl),
    .changed  (carrier_chg),
    .trailing ()
  );

  mspin_edge u_ring (
    .clk      (clk),
    .rst      (rst_mr),
    .pin_n    (ring_indicator_in_n),
    .level    (ring_lvl),
    .changed  (),
    .trailing (ring_trail)
  );

  mspin_baud_gen u_baud (
    .clk     (clk),
    .rst     (rst_mr),
    .divisor ({div_hi_reg, div_lo_reg}),
    .tick    (baud_tick),
    .level   (baud_level)
  );

  // Address decode and read mux
  always_comb begin
    dlab    = lcr_reg[mspin_pkg::LCR_DLAB_BIT];
    rd_idx  = s_axi_araddr[5:2];
    msr_view = '0;
    msr_view.carrier_lvl = carrier_lvl;
    msr_view.ring_lvl    = ring_lvl;
    msr_view.carrier_chg = carrier_chg_reg;
    msr_view.ring_trail  = ring_trail_reg;
    rd_ok   = 1'b1;
    rd_byte = 8'h00;
    case (rd_idx)
      mspin_pkg::IDX_DIV_LO: begin
        rd_ok   = dlab;
        rd_byte = dlab ? div_lo_reg : 8'h00;
      end
      mspin_pkg::IDX_IER: begin
        rd_byte = dlab ? div_hi_reg : ier_reg;
      end
      mspin_pkg::IDX_AFR: begin
        rd_ok   = dlab;
        rd_byte = dlab ? {5'h00, afr_sel_reg, 1'b0} : 8'h00;
      end
      mspin_pkg::IDX_LCR:     rd_byte = lcr_reg;
      mspin_pkg::IDX_MCR:     rd_byte = mcr_reg;
      mspin_pkg::IDX_MSR:     rd_byte = msr_view;
      mspin_pkg::IDX_EVT_ST:  rd_byte = {6'h00, evt_stat_reg};
      mspin_pkg::IDX_EVT_MSK: rd_byte = {6'h00, evt_mask_reg};
      default:                rd_ok   = 1'b0;
    endcase
    case (aw_idx_reg)
      mspin_pkg::IDX_DIV_LO,
      mspin_pkg::IDX_AFR:     wr_ok = dlab;
      mspin_pkg::IDX_IER,
      mspin_pkg::IDX_LCR,
      mspin_pkg::IDX_MCR,
      mspin_pkg::IDX_MSR,
      mspin_pkg::IDX_EVT_ST,
      mspin_pkg::IDX_EVT_MSK: wr_ok = 1'b1;
      default:                wr_ok = 1'b0;
    endcase
  end

  // AXI4-Lite handshakes
  always_comb begin
    aw_got_next = aw_got_reg;
    aw_idx_next = aw_idx_reg;
    w_got_next  = w_got_reg;
    wbyte_next  = wbyte_reg;
    wlane_next  = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      aw_idx_next = s_axi_awaddr[5:2];
    end
    if (s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    wr_fire = aw_got_reg && w_got_reg;
    if (wr_fire) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = wr_ok ? mspin_pkg::RESP_OKAY : mspin_pkg::RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next  = !w_got_next && !bvalid_next;
    rd_fire = s_axi_arvalid && arready_reg;
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rdata_next  = {24'h000000, rd_byte};
      rresp_next  = rd_ok ? mspin_pkg::RESP_OKAY : mspin_pkg::RESP_SLVERR;
    end
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= mspin_pkg::RESP_OKAY;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      aw_idx_reg  <= 4'h0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= mspin_pkg::RESP_OKAY;
    end else begin
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      aw_idx_reg  <= aw_idx_next;
      wbyte_reg   <= wbyte_next;
      wlane_reg   <= wlane_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Register updates, status flags and pin selection
  always_comb begin
    wr_en  = wr_fire && wr_ok && wlane_reg;
    msr_rd = rd_fire && rd_ok && (rd_idx == mspin_pkg::IDX_MSR);
    ier_next      = ier_reg;
    lcr_next      = lcr_reg;
    mcr_next      = mcr_reg;
    afr_sel_next  = afr_sel_reg;
    div_lo_next   = div_lo_reg;
    div_hi_next   = div_hi_reg;
    evt_mask_next = evt_mask_reg;
    evt_w1c       = 2'h0;
    if (wr_en) begin
      case (aw_idx_reg)
        mspin_pkg::IDX_DIV_LO: div_lo_next = wbyte_reg;
        mspin_pkg::IDX_IER: begin
          if (dlab) begin
            div_hi_next = wbyte_reg;
          end else begin
            ier_next = wbyte_reg;
          end
        end
        mspin_pkg::IDX_AFR: begin
          afr_sel_next = wbyte_reg[mspin_pkg::AFR_SEL_MSB:
                                   mspin_pkg::AFR_SEL_LSB];
        end
        mspin_pkg::IDX_LCR:     lcr_next = wbyte_reg;
        mspin_pkg::IDX_MCR:     mcr_next = wbyte_reg;
        mspin_pkg::IDX_EVT_ST:  evt_w1c = wbyte_reg[1:0];
        mspin_pkg::IDX_EVT_MSK: evt_mask_next = wbyte_reg[1:0];
        default:                evt_w1c = 2'h0;
      endcase
    end
    // New events win over a clearing read or write
    carrier_chg_next = (carrier_chg_reg & ~msr_rd) | carrier_chg;
    ring_trail_next  = (ring_trail_reg & ~msr_rd) | ring_trail;
    evt_set = 2'h0;
    evt_set[mspin_pkg::EVT_CARRIER] = carrier_chg;
    evt_set[mspin_pkg::EVT_RING]    = ring_trail;
    evt_stat_next = (evt_stat_reg & ~evt_w1c & ~{2{msr_rd}}) | evt_set;
    irq_next = ier_reg[mspin_pkg::IER_MSI_BIT] &
               (|(evt_stat_next & evt_mask_next));
    // Pin is active low and idles high in loopback
    general_output_two_pin = ~(mcr_reg[mspin_pkg::MCR_GENERAL_OUTPUT_TWO_BIT] &
                 ~mcr_reg[mspin_pkg::MCR_LOOP_BIT]);
    case (mspin_pkg::mspin_mf_sel_e'(afr_sel_reg))
      mspin_pkg::MF_GENERAL_OUTPUT_TWO:  mf_next = general_output_two_pin;
      mspin_pkg::MF_BAUD:  mf_next = baud_level;
      mspin_pkg::MF_RECEIVE_DMA_REQUEST: mf_next = receive_dma_request_n;
      default:             mf_next = general_output_two_pin;
    endcase
  end

  // Registers cleared by master reset; divisor only by system reset
  always_ff @(posedge clk) begin
    if (rst_mr) begin
      ier_reg         <= mspin_pkg::IER_RST;
      lcr_reg         <= mspin_pkg::LCR_RST;
      mcr_reg         <= mspin_pkg::MCR_RST;
      afr_sel_reg     <= mspin_pkg::AFR_RST;
      carrier_chg_reg <= 1'b0;
      ring_trail_reg  <= 1'b0;
      evt_stat_reg    <= mspin_pkg::EVT_RST;
      evt_mask_reg    <= mspin_pkg::EVT_RST;
      irq_reg         <= 1'b0;
      mf_reg          <= 1'b1;
      baud_out_reg    <= 1'b0;
      rx_tick_reg     <= 1'b0;
    end else begin
      ier_reg         <= ier_next;
      lcr_reg         <= lcr_next;
      mcr_reg         <= mcr_next;
      afr_sel_reg     <= afr_sel_next;
      carrier_chg_reg <= carrier_chg_next;
      ring_trail_reg  <= ring_trail_next;
      evt_stat_reg    <= evt_stat_next;
      evt_mask_reg    <= evt_mask_next;
      irq_reg         <= irq_next;
      mf_reg          <= mf_next;
      baud_out_reg    <= baud_level;
      // Receiver tick taken from baud only, never from carrier
      rx_tick_reg     <= baud_tick;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_lo_reg <= mspin_pkg::DIV_LO_RST;
      div_hi_reg <= mspin_pkg::DIV_HI_RST;
    end else begin
      div_lo_reg <= div_lo_next;
      div_hi_reg <= div_hi_next;
    end
  end

  // Outputs
  assign s_axi_awready  = awready_reg;
  assign s_axi_wready   = wready_reg;
  assign s_axi_bvalid   = bvalid_reg;
  assign s_axi_bresp    = bresp_reg;
  assign s_axi_arready  = arready_reg;
  assign s_axi_rvalid   = rvalid_reg;
  assign s_axi_rdata    = rdata_reg;
  assign s_axi_rresp    = rresp_reg;
  assign multifunc_out  = mf_reg;
  assign baud_clock_out = baud_out_reg;
  assign rx_sample_tick = rx_tick_reg;
  assign irq            = irq_reg;

endmodule : mspin_top
`default_nettype wire

/* hdl/mspin_pkg.sv */
// Constants, types and register map of the modem status and multifunction pin
`default_nettype none
package mspin_pkg;

  // Register indices; byte address is four times the index
  localparam int unsigned ADDR_W      = 6;
  localparam int unsigned IDX_LSB     = 2;
  localparam logic [3:0]  IDX_DIV_LO  = 4'h0;
  localparam logic [3:0]  IDX_DIV_HI  = 4'h1;
  localparam logic [3:0]  IDX_IER     = 4'h1;
  localparam logic [3:0]  IDX_AFR     = 4'h2;
  localparam logic [3:0]  IDX_LCR     = 4'h3;
  localparam logic [3:0]  IDX_MCR     = 4'h4;
  localparam logic [3:0]  IDX_MSR     = 4'h6;
  localparam logic [3:0]  IDX_EVT_ST  = 4'h8;
  localparam logic [3:0]  IDX_EVT_MSK = 4'h9;

  // Field positions
  localparam int unsigned IER_MSI_BIT  = 3;
  localparam int unsigned LCR_DLAB_BIT = 7;
  localparam int unsigned MCR_GENERAL_OUTPUT_TWO_BIT = 3;
  localparam int unsigned MCR_LOOP_BIT = 4;
  localparam int unsigned AFR_SEL_LSB  = 1;
  localparam int unsigned AFR_SEL_MSB  = 2;
  localparam int unsigned EVT_CARRIER  = 0;
  localparam int unsigned EVT_RING     = 1;

  // Values after reset
  localparam logic [7:0]  IER_RST = 8'h00;
  localparam logic [7:0]  LCR_RST = 8'h00;
  localparam logic [7:0]  MCR_RST = 8'h00;
  localparam logic [1:0]  AFR_RST = 2'h0;
  localparam logic [1:0]  EVT_RST = 2'h0;
  localparam logic [7:0]  DIV_LO_RST = 8'h01;
  localparam logic [7:0]  DIV_HI_RST = 8'h00;

  // AXI responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Multifunction pin selection
  typedef enum logic [1:0] {
    MF_GENERAL_OUTPUT_TWO,
    MF_BAUD,
    MF_RECEIVE_DMA_REQUEST,
    MF_SPARE
  } mspin_mf_sel_e;

  // Modem status register layout
  typedef struct packed {
    logic carrier_lvl;
    logic ring_lvl;
    logic dsr_lvl;
    logic cts_lvl;
    logic carrier_chg;
    logic ring_trail;
    logic dsr_chg;
    logic cts_chg;
  } mspin_msr_s;

endpackage : mspin_pkg
`default_nettype wire

/* hdl/mspin_edge.sv */
// Complemented level and change detection for one modem status input
`default_nettype none
module mspin_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Pin, active low
  input  wire logic pin_n,
  // Status
  output logic      level,
  output logic      changed,
  output logic      trailing
);

  logic level_reg;
  logic level_next;
  logic chg_reg;
  logic chg_next;
  logic trail_reg;
  logic trail_next;

  always_comb begin
    level_next = ~pin_n;
    chg_next   = level_next != level_reg;
    trail_next = level_reg & ~level_next;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= 1'b0;
      chg_reg   <= 1'b0;
      trail_reg <= 1'b0;
    end else begin
      level_reg <= level_next;
      chg_reg   <= chg_next;
      trail_reg <= trail_next;
    end
  end

  assign level    = level_reg;
  assign changed  = chg_reg;
  assign trailing = trail_reg;

endmodule : mspin_edge
`default_nettype wire

/* hdl/mspin_baud_gen.sv */
// Divisor counter making the 16x baud clock level and sample tick
`default_nettype none
module mspin_baud_gen (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Divisor
  input  wire logic [15:0] divisor,
  // Outputs
  output logic             tick,
  output logic             level
);

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        tick_reg;
  logic        tick_next;
  logic        level_reg;
  logic        level_next;

  always_comb begin
    if (cnt_reg == 16'h0000) begin
      cnt_next = divisor - 16'h0001;
    end else begin
      cnt_next = cnt_reg - 16'h0001;
    end
    tick_next  = cnt_reg == 16'h0000;
    level_next = cnt_next >= {1'b0, divisor[15:1]};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg   <= 16'h0000;
      tick_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      tick_reg  <= tick_next;
      level_reg <= level_next;
    end
  end

  assign tick  = tick_reg;
  assign level = level_reg;

endmodule : mspin_baud_gen
`default_nettype wire

/* tb/mspin_asserts.sv */
// Port checker for the modem status and multifunction pin block
`default_nettype none
module mspin_asserts (
  // Clock and resets
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        master_reset_in,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic        carrier_detect_in_n,
  input wire logic        ring_indicator_in_n,
  input wire logic        multifunc_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cd_q_reg, ri_q_reg;
  logic       ok_reg, cd_exp_reg, ri_exp_reg, ar_st;

  assign ar_st = s_axi_arvalid && s_axi_arready &&
                 s_axi_araddr[5:2] == mspin_pkg::IDX_MSR;

  // Cycles each pin has been steady, saturating
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cd_q_reg <= 4'h0;
      ri_q_reg <= 4'h0;
      ok_reg   <= 1'b0;
    end else begin
      cd_q_reg <= $stable(carrier_detect_in_n) ?
                  cd_q_reg + {3'h0, ~&cd_q_reg} : 4'h0;
      ri_q_reg <= $stable(ring_indicator_in_n) ?
                  ri_q_reg + {3'h0, ~&ri_q_reg} : 4'h0;
      if (s_axi_arvalid && s_axi_arready) begin
        ok_reg <= ar_st && cd_q_reg > 4'h3 && ri_q_reg > 4'h3;
        cd_exp_reg <= ~carrier_detect_in_n;
        ri_exp_reg <= ~ring_indicator_in_n;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read data late");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("resp dropped");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  a_carrier_level: assert property ($rose(s_axi_rvalid) && ok_reg
    |-> s_axi_rdata[7] == cd_exp_reg) else $error("carrier bit wrong");
  a_ring_level: assert property ($rose(s_axi_rvalid) && ok_reg
    |-> s_axi_rdata[6] == ri_exp_reg) else $error("ring bit wrong");
  a_master_reset: assert property (master_reset_in
    |-> ##2 (multifunc_out && !irq)) else $error("master reset missed");
  a_irq_clear: assert property (ar_st && cd_q_reg > 4'h3
    && ri_q_reg > 4'h3 |-> ##[1:3] !irq) else $error("irq not cleared");
endmodule : mspin_asserts
`default_nettype wire

/* tb/mspin_modem_model.sv */
// Remote modem driving the carrier and ring status pins
`default_nettype none
module mspin_modem_model (
  // Clock
  input  wire logic       clk,
  // Commanded states, high means asserted
  input  wire logic       want_carrier,
  input  wire logic       want_ring,
  input  wire logic [1:0] lag,
  // Status pins, active low
  output logic            carrier_detect_in_n,
  output logic            ring_indicator_in_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] cnt = 2'h0;
  initial carrier_detect_in_n = 1'b1;
  initial ring_indicator_in_n = 1'b1;
  // Follow the command after a lag of up to three cycles
  always @(posedge clk) begin
    if (cnt < lag && {want_carrier, want_ring} !=
        ~{carrier_detect_in_n, ring_indicator_in_n}) begin
      cnt <= cnt + 2'h1;
    end else begin
      cnt <= 2'h0;
      carrier_detect_in_n <= ~want_carrier;
      ring_indicator_in_n <= ~want_ring;
    end
  end
endmodule : mspin_modem_model
`default_nettype wire

/* tb/test_modem_status_multifunc_pin.sv */
// Self-checking bench for the modem status and multifunction pin
`default_nettype none
module test_modem_status_multifunc_pin;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, master_reset_in, receive_dma_request_n;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, lag;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, cd_w, ri_w;
  logic        multifunc_out, baud_clock_out, rx_sample_tick, irq;
  wire         carrier_detect_in_n, ring_indicator_in_n;
  int          err_count = 0;
  int          checks_done = 0;
  localparam logic [1:0] OK = mspin_pkg::RESP_OKAY;
  localparam logic [1:0] SE = mspin_pkg::RESP_SLVERR;

  mspin_top dut_u (.*);
  mspin_modem_model modem_u (.clk(clk), .want_carrier(cd_w),
    .want_ring(ri_w), .lag(lag),
    .carrier_detect_in_n(carrier_detect_in_n),
    .ring_indicator_in_n(ring_indicator_in_n));

  task automatic complete_run();
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  task automatic tmo(input int n);
    if (n < 60) return;
    err_count++;
    complete_run();
  endtask : tmo

  task automatic wr(input logic [3:0] i, input logic [7:0] v,
                    input logic [1:0] e);
    int   n, w;
    logic dn;
    n = 0;
    w = $urandom_range(2);
    s_axi_awaddr  <= {i, 2'h0};
    s_axi_wdata   <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (w == 0);
    do begin
      @(posedge clk);
      n++;
      dn = s_axi_bvalid && s_axi_bready;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (!dn && n >= w) s_axi_bready <= 1'b1;
    end while (!dn && n < 60);
    tmo(n);
    chk(s_axi_bresp, e);
    s_axi_bready <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [3:0] i, input logic [1:0] e,
                    output logic [31:0] d);
    int   n, w;
    logic dn;
    n = 0;
    w = $urandom_range(2);
    s_axi_araddr  <= {i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= (w == 0);
    do begin
      @(posedge clk);
      n++;
      dn = s_axi_rvalid && s_axi_rready;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!dn && n >= w) s_axi_rready <= 1'b1;
    end while (!dn && n < 60);
    tmo(n);
    d = s_axi_rdata;
    chk(s_axi_rresp, e);
    s_axi_rready <= 1'b0;
    @(posedge clk);
  endtask : rd

  // Ticks and baud rising edges over forty cycles, carrier driven at random
  task automatic cnt40(output int t, output int b);
    logic p;
    t = 0;
    b = 0;
    p = baud_clock_out;
    repeat (40) begin
      @(posedge clk);
      t += rx_sample_tick;
      b += baud_clock_out && !p;
      p = baud_clock_out;
      cd_w <= 1'($urandom_range(1));
    end
  endtask : cnt40

  function automatic logic exp_mf(input logic [1:0] sel, input logic o);
    case (sel)
      2'h1: return 1'b1;
      2'h2: return receive_dma_request_n;
      default: return ~o;
    endcase
  endfunction : exp_mf

  // Expected status byte from new and previous pin commands
  function automatic logic [31:0] exp_status(input logic c, input logic r,
                                             input logic c0, input logic r0);
    return {24'h0, c, r, 2'h0, c != c0, r0 && !r, 2'h0};
  endfunction : exp_status

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    logic [31:0] d;
    logic        pc, pr, nc, nr;
    int          t, b;
    void'($urandom(32'hcdae));
    {sys_rst, s_axi_wstrb} = 5'h11;
    {master_reset_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, cd_w, ri_w, lag} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 44'h0;
    receive_dma_request_n = 1'b1;
    repeat (4) @(posedge clk);
    chk(multifunc_out, 1'b1);
    chk(irq, 1'b0);
    sys_rst <= 1'b0;
    rd(mspin_pkg::IDX_LCR, OK, d);
    chk(d, 32'h0);
    rd(mspin_pkg::IDX_MSR, OK, d);
    chk(d, 32'h0);
    rd(4'hb, SE, d);
    chk(d, 32'h0);
    rd(mspin_pkg::IDX_DIV_LO, SE, d);
    wr(4'hb, 8'hff, SE);
    wr(mspin_pkg::IDX_IER, 8'h08, OK);
    wr(mspin_pkg::IDX_EVT_MSK, 8'h01, OK);
    pc = 1'b0;
    pr = 1'b0;
    for (int k = 0; k < 12; k++) begin
      nc = pc;
      nr = pr;
      if ($urandom_range(1)) nc = ~pc;
      else nr = ~pr;
      cd_w <= nc;
      ri_w <= nr;
      lag  <= 2'($urandom_range(3));
      repeat (10) @(posedge clk);
      chk(irq, nc != pc);
      rd(mspin_pkg::IDX_MSR, OK, d);
      chk(d, exp_status(nc, nr, pc, pr));
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
      pc = nc;
      pr = nr;
    end
    ri_w <= 1'b1;
    repeat (10) @(posedge clk);
    rd(mspin_pkg::IDX_MSR, OK, d);
    ri_w <= 1'b0;
    repeat (10) @(posedge clk);
    chk(irq, 1'b0);
    rd(mspin_pkg::IDX_EVT_ST, OK, d);
    chk(d, 32'h2);
    wr(mspin_pkg::IDX_EVT_MSK, 8'h02, OK);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    wr(mspin_pkg::IDX_EVT_ST, 8'h02, OK);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    wr(mspin_pkg::IDX_LCR, 8'h80, OK);
    for (int s = 0; s < 8; s++) begin
      wr(mspin_pkg::IDX_AFR, {5'h0, 2'(s), 1'b0}, OK);
      wr(mspin_pkg::IDX_MCR, {4'h0, s[2], 3'h0}, OK);
      receive_dma_request_n <= 1'($urandom_range(1));
      repeat (3) @(posedge clk);
      chk(multifunc_out, exp_mf(2'(s), s[2]));
    end
    wr(mspin_pkg::IDX_MCR, 8'h18, OK);
    repeat (3) @(posedge clk);
    chk(multifunc_out, 1'b1);
    wr(mspin_pkg::IDX_MCR, 8'h08, OK);
    wr(mspin_pkg::IDX_DIV_LO, 8'h04, OK);
    repeat (4) @(posedge clk);
    cnt40(t, b);
    chk(t, 10);
    chk(b, 10);
    chk(multifunc_out, 1'b0);
    master_reset_in <= 1'b1;
    repeat (2) @(posedge clk);
    master_reset_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk(multifunc_out, 1'b1);
    rd(mspin_pkg::IDX_MCR, OK, d);
    chk(d, 32'h0);
    rd(mspin_pkg::IDX_IER, OK, d);
    chk(d, 32'h0);
    // Selection must be back on output two after master reset
    wr(mspin_pkg::IDX_MCR, 8'h08, OK);
    repeat (2) @(posedge clk);
    chk(multifunc_out, 1'b0);
    cnt40(t, b);
    chk(t, 10);
    complete_run();
  end
endmodule : test_modem_status_multifunc_pin

bind mspin_top mspin_asserts chk_u (.*);
`default_nettype wire
